// [sbsr_pkg.sv]
package sbsr_pkg;
   localparam int STATUS_W = 8;
   localparam int BIT_POINT_DONE = 0;
   localparam int BIT_SWEEP_DONE = 1;
   localparam int BIT_UNUSED_LO = 2;
   localparam int BIT_END_STATUS = 3;
   localparam int BIT_TRIG_FAST = 4;
   localparam int BIT_ERROR = 5;
   localparam int BIT_REQ_SERVICE = 6;
   localparam int BIT_UNUSED_HI = 7;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Bits 2 and 7 never hold a value
   localparam logic [7:0] STATUS_LIVE = 8'h7B;
   localparam logic [7:0] MASKABLE = 8'h3B;

   typedef struct packed {
      logic point_done;
      logic sweep_done;
      logic end_status;
      logic trig_cmd;
      logic int_trig_mode;
      logic meas_busy;
      logic error_seen;
   } sbsr_events_t;

   typedef struct packed {
      logic clear_status_command;
      logic status_query_command;
      logic serial_poll;
      logic mask_write;
      logic [7:0] mask_data;
   } sbsr_ctrl_t;
endpackage

// [sbsr_event_set.sv]
`timescale 1ns/1ps
module sbsr_event_set (
   input wire sbsr_pkg::sbsr_events_t ev,
   output logic [7:0] set_bits
);
   always_comb begin
      set_bits = 8'h00;
      set_bits[sbsr_pkg::BIT_POINT_DONE] = ev.point_done;
      set_bits[sbsr_pkg::BIT_SWEEP_DONE] = ev.sweep_done;
      set_bits[sbsr_pkg::BIT_END_STATUS] = ev.end_status;
      set_bits[sbsr_pkg::BIT_TRIG_FAST] = ev.trig_cmd & (ev.int_trig_mode | ev.meas_busy);
      set_bits[sbsr_pkg::BIT_ERROR] = ev.error_seen;
   end
endmodule

// [sbsr_status_byte.sv]
`timescale 1ns/1ps
// Contract
// - Trigger while internal or busy sets bit4
// - Any error sets bit 5
// - Request granted sets bit6; poll clears
// - Request bit ignores enable mask
// - Bits 2 and 7 read zero
// - Clear command zeroes status byte
// - Poll with bit6 set clears byte
// - Status query leaves byte unchanged
// - Mask bit enables same status bit
// - Enabled set bit raises service request
// - Eight-bit byte presented on poll
// - Point done sets bit 0
// - Sweep done sets bit 1
// - Copy/program/cal done sets bit 3
module sbsr_status_byte (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire sbsr_pkg::sbsr_events_t events,
   input wire sbsr_pkg::sbsr_ctrl_t ctrl,
   output logic [7:0] event_status_byte,
   output logic [7:0] poll_byte,
   output logic poll_valid,
   output logic [7:0] query_byte,
   output logic query_valid,
   output logic service_request
);
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] mask;
      logic [7:0] poll_byte;
      logic poll_valid;
      logic [7:0] query_byte;
      logic query_valid;
   } sbsr_state_t;

   sbsr_state_t st;
   sbsr_state_t next_st;
   logic [7:0] set_bits;
   logic [7:0] cur;

   sbsr_event_set u_events (
      .ev(events),
      .set_bits(set_bits)
   );

   always_comb begin
      next_st = st;
      next_st.poll_valid = 1'b0;
      next_st.query_valid = 1'b0;
      cur = st.status;
      if (ctrl.mask_write) begin
         next_st.mask = ctrl.mask_data;
      end
      if (ctrl.status_query_command) begin
         next_st.query_byte = cur;
         next_st.query_valid = 1'b1;
      end
      if (ctrl.serial_poll) begin
         next_st.poll_byte = cur;
         next_st.poll_valid = 1'b1;
      end
      if (ctrl.clear_status_command) begin
         next_st.status = sbsr_pkg::STATUS_RESET;
      end else if (ctrl.serial_poll && cur[sbsr_pkg::BIT_REQ_SERVICE]) begin
         next_st.status = sbsr_pkg::STATUS_RESET;
      end
      // New events win over any clear
      next_st.status = next_st.status | set_bits;
      // request granted from enabled bits; mask never gates bit 6
      if ((next_st.status & st.mask & sbsr_pkg::MASKABLE) != 8'h00) begin
         next_st.status[sbsr_pkg::BIT_REQ_SERVICE] = 1'b1;
      end
      next_st.status = next_st.status & sbsr_pkg::STATUS_LIVE;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st.status <= sbsr_pkg::STATUS_RESET;
         st.mask <= sbsr_pkg::MASK_RESET;
         st.poll_byte <= 8'h00;
         st.poll_valid <= 1'b0;
         st.query_byte <= 8'h00;
         st.query_valid <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign event_status_byte = st.status;
   assign poll_byte = st.poll_byte;
   assign poll_valid = st.poll_valid;
   assign query_byte = st.query_byte;
   assign query_valid = st.query_valid;
   assign service_request = st.status[sbsr_pkg::BIT_REQ_SERVICE];

   // Events set flags in the same edge that a clear or poll empties the byte,
   // so the checks below allow for set_bits where a clear is involved

   chk_unused_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !st.status[sbsr_pkg::BIT_UNUSED_LO] && !st.status[sbsr_pkg::BIT_UNUSED_HI])
      else $error("unused status bit set");

   chk_clear_cmd: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl.clear_status_command && set_bits == 8'h00
      |=> st.status == sbsr_pkg::STATUS_RESET)
      else $error("clear command did not clear");

   chk_poll_clear: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl.serial_poll && st.status[sbsr_pkg::BIT_REQ_SERVICE] && set_bits == 8'h00
      |=> st.status == sbsr_pkg::STATUS_RESET && poll_valid
          && poll_byte == $past(st.status))
      else $error("poll did not present and clear");

   chk_poll_keep: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl.serial_poll && !st.status[sbsr_pkg::BIT_REQ_SERVICE] && !ctrl.clear_status_command
      |=> (st.status & sbsr_pkg::MASKABLE)
          == (($past(st.status) | $past(set_bits)) & sbsr_pkg::MASKABLE))
      else $error("poll without request changed the byte");

   chk_poll_byte: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl.serial_poll |=> poll_valid && poll_byte == $past(st.status))
      else $error("poll byte not presented");

   chk_query_keep: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl.status_query_command && !ctrl.clear_status_command && !ctrl.serial_poll
      |=> query_valid && query_byte == $past(st.status)
          && (st.status & sbsr_pkg::MASKABLE)
          == (($past(st.status) | $past(set_bits)) & sbsr_pkg::MASKABLE)
          && (service_request || !$past(service_request)))
      else $error("query changed the byte");

   chk_trig_fast: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      events.trig_cmd && (events.int_trig_mode || events.meas_busy)
      |=> st.status[sbsr_pkg::BIT_TRIG_FAST])
      else $error("trigger too fast missed");

   chk_error_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      events.error_seen |=> st.status[sbsr_pkg::BIT_ERROR])
      else $error("error flag missed");

   chk_point_done: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      events.point_done |=> st.status[sbsr_pkg::BIT_POINT_DONE])
      else $error("point done flag missed");

   chk_sweep_done: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      events.sweep_done |=> st.status[sbsr_pkg::BIT_SWEEP_DONE])
      else $error("sweep done flag missed");

   chk_end_status: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      events.end_status |=> st.status[sbsr_pkg::BIT_END_STATUS])
      else $error("end status flag missed");

   chk_srq_raise: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (set_bits & st.mask & sbsr_pkg::MASKABLE) != 8'h00 |=> service_request)
      else $error("service request not raised");

   chk_srq_grant: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(service_request)
      |-> (($past(st.status) | $past(set_bits)) & $past(st.mask) & sbsr_pkg::MASKABLE)
          != 8'h00)
      else $error("service request without enabled flag");

   chk_req_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      service_request && !ctrl.serial_poll && !ctrl.clear_status_command
      |=> service_request)
      else $error("request flag dropped without poll or clear");

   chk_srq_follow: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      service_request == st.status[sbsr_pkg::BIT_REQ_SERVICE] && (service_request
      || ((st.status & st.mask & sbsr_pkg::MASKABLE) == 8'h00) || $past(ctrl.mask_write)))
      else $error("request line out of step");

   chk_mask_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ctrl.mask_write |=> st.mask == $past(ctrl.mask_data))
      else $error("mask write lost");

   chk_mask_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !ctrl.mask_write |=> st.mask == $past(st.mask))
      else $error("mask changed without a write");
endmodule

// [sbsr_host.sv]
`timescale 1ns/1ps
module sbsr_host (
   input wire logic clk_sys,
   output sbsr_pkg::sbsr_ctrl_t ctrl
);
   initial ctrl = '0;
   task automatic cmd(input logic [3:0] kind, input logic [7:0] mask);
      @(negedge clk_sys);
      ctrl <= {kind, mask};
      @(negedge clk_sys);
      ctrl <= '0;
   endtask
endmodule

// [test_sbsr_status_byte.sv]
`timescale 1ns/1ps
module test_sbsr_status_byte;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   sbsr_pkg::sbsr_events_t events = '0;
   sbsr_pkg::sbsr_ctrl_t ctrl;
   logic [7:0] status;
   logic [7:0] poll_byte;
   logic [7:0] query_byte;
   logic poll_valid;
   logic query_valid;
   logic sreq;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   always #5 clk_sys = ~clk_sys;
   sbsr_host HOST (.clk_sys(clk_sys), .ctrl(ctrl));
   sbsr_status_byte DUT (.clk_sys(clk_sys), .rst_n(rst_n), .events(events), .ctrl(ctrl),
      .event_status_byte(status), .poll_byte(poll_byte), .poll_valid(poll_valid),
      .query_byte(query_byte), .query_valid(query_valid), .service_request(sreq));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ev(input logic [6:0] e);
      @(negedge clk_sys);
      events = e;
      @(negedge clk_sys);
      events = '0;
   endtask
   task automatic stop_test();
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Test needs about 35 cycles; a hang stops far beyond that
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      ev(7'h40);
      cmp(status, 8'h01);
      cmp({7'h00, sreq}, 8'h00);
      HOST.cmd(4'h1, 8'h02);
      ev(7'h20);
      cmp(status, 8'h43);
      cmp({7'h00, sreq}, 8'h01);
      HOST.cmd(4'h4, 8'h00);
      cmp({7'h00, query_valid}, 8'h01);
      cmp(query_byte, 8'h43);
      cmp(status, 8'h43);
      HOST.cmd(4'h2, 8'h00);
      cmp({7'h00, poll_valid}, 8'h01);
      cmp(poll_byte, 8'h43);
      cmp(status, 8'h00);
      cmp({7'h00, sreq}, 8'h00);
      HOST.cmd(4'h1, 8'hFF);
      ev(7'h10);
      cmp(status, 8'h48);
      HOST.cmd(4'h8, 8'h00);
      cmp(status, 8'h00);
      cmp({7'h00, sreq}, 8'h00);
      HOST.cmd(4'h1, 8'h84);
      ev(7'h0C);
      cmp(status, 8'h10);
      HOST.cmd(4'h8, 8'h00);
      ev(7'h08);
      cmp(status, 8'h00);
      ev(7'h0A);
      cmp(status, 8'h10);
      ev(7'h01);
      cmp(status, 8'h30);
      HOST.cmd(4'h2, 8'h00);
      cmp(poll_byte, 8'h30);
      cmp(status, 8'h30);
      HOST.cmd(4'h1, 8'h20);
      @(negedge clk_sys);
      cmp(status, 8'h70);
      cmp({7'h00, sreq}, 8'h01);
      stop_test();
   end
endmodule
